// ==== pkg/dsb_cfg.svh ====
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH
// Avalon register byte offsets
`define DSB_OFF_SETUP   6'h00
`define DSB_OFF_MADDR   6'h04
`define DSB_OFF_MCMD    6'h08
`define DSB_OFF_MSTAT   6'h0C
`define DSB_OFF_WDATA   6'h10
`define DSB_OFF_RDATA   6'h14
`define DSB_OFF_SLVREG  6'h18
// Field positions
`define DSB_SETUP_BURST 0
`define DSB_SETUP_MODE  1
`define DSB_MCMD_DIR    0
`define DSB_MCMD_DESC   1
`define DSB_MCMD_LEN_LO 2
`define DSB_MSTAT_BUSY  0
`define DSB_MSTAT_DONE  1
`define DSB_MSTAT_STOP  2
`define DSB_MSTAT_ERR   3
`define DSB_MSTAT_CNT   4
// Reset values and counts
`define DSB_RST_SETUP   1'h0
`define DSB_RST_WORD    32'h0000_0000
`define DSB_DESC_MAX    3'h3
`define DSB_BURST_MAX   3'h4
`define DSB_FIFO_DEPTH  8
`define DSB_ID_WORD     32'h1234_5678
`endif

// ==== pkg/dsb_pkg.sv ====
package dsb_pkg;
   typedef enum logic [4:0] {
      M_IDLE = 5'b00001,
      M_ADDR = 5'b00010,
      M_DATA = 5'b00100,
      M_GAP  = 5'b01000,
      M_TURN = 5'b10000
   } dsb_mst_type;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_WAIT = 4'b0010,
      S_DATA = 4'b0100,
      S_END  = 4'b1000
   } dsb_slv_type;
endpackage

// ==== hw/dsb_fifo.sv ====
`timescale 1ns/100ps
module dsb_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== hw/dsb_top.sv ====
// How it works
// [RQ1] Offers a 32-bit synchronous demultiplexed host bus as PCI alternative.
// [RQ2] Mode select pin: low means PCI, high means demultiplexed; tied.
// [RQ3] Handshakes follow PCI protocol; only address and command differ.
// [RQ4] No command nibble; a two-way write/read strobe gives direction.
// [RQ5] Separate address bus carries bits 31:2, driven by the master.
// [RQ6] Address valid from frame fall through address, turnaround, data.
// [RQ7] Write/read strobe valid from frame fall through the whole data phase.
// [RQ8] As master, drive only the first burst address; never advance it.
// [RQ9] Outside logic increments burst addresses; burst order bits unsupported.
// [RQ10] Burst enable allows up to four words, only in demultiplexed mode.
// [RQ11] Burst enable clear: every master transfer is one word.
// [RQ12] Burst enable set: descriptors up to three words, payload one word.
// [RQ13] Target stop ends the current master transaction even in bursts.
// [RQ14] Master read is strobe 0, write strobe 1; config select never used.
// [RQ15] Slave: config select low is register access, high config access.
// [RQ16] Outside glue meets timing, may stretch master cycles with ready.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "dsb_cfg.svh"
module dsb_top import dsb_pkg::*; #(
   parameter logic [31:0] ID_WORD  = `DSB_ID_WORD, // Arbitrary value
   parameter logic [25:0] SLV_BASE = 26'h0000000,
   parameter int          DEPTH    = `DSB_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Strap and arbitration
   input  wire logic        bus_mode_select,
   input  wire logic        idsel,
   input  wire logic        gnt_n,
   output logic             req_n,
   // Handshake pins
   input  wire logic        frame_n_i,
   output logic             frame_n_o,
   output logic             frame_n_oe,
   input  wire logic        irdy_n_i,
   output logic             irdy_n_o,
   output logic             irdy_n_oe,
   input  wire logic        trdy_n_i,
   output logic             trdy_n_o,
   output logic             trdy_n_oe,
   input  wire logic        stop_n_i,
   output logic             stop_n_o,
   output logic             stop_n_oe,
   input  wire logic        devsel_n_i,
   output logic             devsel_n_o,
   output logic             devsel_n_oe,
   // Address, strobe and data
   input  wire logic [29:0] addr_i,
   output logic      [29:0] addr_o,
   output logic             addr_oe,
   input  wire logic        wr_i,
   output logic             wr_o,
   output logic             wr_oe,
   input  wire logic [31:0] ad_i,
   output logic      [31:0] ad_o,
   output logic             ad_oe
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops each
   localparam int SW = 1 + 1 + 1 + 1 + 1 + 1 + 1 + 30 + 1 + 32;
   logic [SW-1:0] sy1_q;
   logic [SW-1:0] sy2_q;
   logic          mode_s, idsel_s, gnt_n_s, frame_s, irdy_s, trdy_s, stop_s;
   logic [29:0]   addr_s;
   logic          wr_s;
   logic [31:0]   ad_s; // [RQ1]
   logic          frame_p_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sy1_q <= '1;
         sy2_q <= '1;
      end else begin
         sy1_q <= {bus_mode_select, idsel, gnt_n, frame_n_i, irdy_n_i,
                   trdy_n_i, stop_n_i, addr_i, wr_i, ad_i};
         sy2_q <= sy1_q;
      end
   end
   assign {mode_s, idsel_s, gnt_n_s, frame_s, irdy_s, trdy_s, stop_s,
           addr_s, wr_s, ad_s} = sy2_q;

   ////////////////////////////////////////////////////////////////////////
   // Avalon registers
   logic        burst_enable_bit_q;
   logic [29:0] maddr_q;
   logic        mdir_q, mdesc_q, start_q;
   logic [1:0]  mlen_q;
   logic [31:0] wbuf_q [4];
   logic [1:0]  widx_q;
   logic        done_q, stopd_q, err_q;
   logic [31:0] slv_reg_q;
   logic        acc, wr_acc, rd_acc;
   logic        f_out_valid, f_in_ready, f_pop, f_push;
   logic [31:0] f_out_data;
   dsb_mst_type mst_q;
   logic [2:0]  nwords_q, cnt_q;

   assign acc    = !avs_waitrequest && (avs_read || avs_write);
   assign wr_acc = acc && avs_write;
   assign rd_acc = acc && avs_read;
   assign f_pop  = rd_acc && avs_address == `DSB_OFF_RDATA && f_out_valid;

   // One wait state on every access, so readdata is always registered
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= `DSB_RST_WORD;
      end else if (avs_waitrequest && (avs_read || avs_write)) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= `DSB_RST_WORD;
         if (avs_read) begin
            case (avs_address)
               `DSB_OFF_SETUP:  avs_readdata <= {30'h0, mode_s,
                                                 burst_enable_bit_q};
               `DSB_OFF_MADDR:  avs_readdata <= {maddr_q, 2'h0};
               `DSB_OFF_MCMD:   avs_readdata <= {28'h0, mlen_q, mdesc_q,
                                                 mdir_q};
               `DSB_OFF_MSTAT:  avs_readdata <= {25'h0, cnt_q, err_q,
                                                 stopd_q, done_q,
                                                 mst_q != M_IDLE};
               `DSB_OFF_RDATA:  avs_readdata <= f_out_valid ? f_out_data
                                                            : 32'h0;
               `DSB_OFF_SLVREG: avs_readdata <= slv_reg_q;
               default:         avs_readdata <= `DSB_RST_WORD;
            endcase
         end
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         burst_enable_bit_q <= `DSB_RST_SETUP;
         maddr_q            <= 30'h0;
         {mlen_q, mdesc_q, mdir_q} <= 4'h0;
         widx_q             <= 2'h0;
      end else if (wr_acc) begin
         case (avs_address)
            `DSB_OFF_SETUP: burst_enable_bit_q <=
                               avs_writedata[`DSB_SETUP_BURST];
            `DSB_OFF_MADDR: maddr_q <= avs_writedata[31:2];
            `DSB_OFF_MCMD: if (mst_q == M_IDLE && mode_s) begin
               mdir_q  <= avs_writedata[`DSB_MCMD_DIR];
               mdesc_q <= avs_writedata[`DSB_MCMD_DESC];
               mlen_q  <= avs_writedata[`DSB_MCMD_LEN_LO +: 2];
               widx_q  <= 2'h0;
            end
            `DSB_OFF_WDATA: widx_q <= widx_q + 2'h1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (wr_acc && avs_address == `DSB_OFF_WDATA) begin
         wbuf_q[widx_q] <= avs_writedata;
      end
   end

   // Command accepted only when idle and in demultiplexed mode
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         start_q <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (wr_acc && avs_address == `DSB_OFF_MCMD) begin
            if (mst_q == M_IDLE && mode_s) start_q <= 1'b1;  // [RQ2]
            else                           err_q   <= 1'b1;
         end else if (wr_acc && avs_address == `DSB_OFF_MSTAT) begin
            err_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data buffer; a full buffer holds irdy off and stalls the bus
   dsb_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_valid  (f_push),
      .in_ready  (f_in_ready),
      .in_data   (ad_s),
      .out_valid (f_out_valid),
      .out_ready (f_pop),
      .out_data  (f_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Master engine
   logic        ack, room;
   logic [2:0]  req_len;
   logic        slv_busy;

   assign ack     = mst_q == M_DATA && !irdy_n_o && (!trdy_s || !stop_s);
   assign f_push  = ack && !trdy_s && !mdir_q;
   assign req_len = {1'b0, mlen_q} + 3'h1;
   assign room    = mdir_q || f_in_ready;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mst_q     <= M_IDLE;
         nwords_q  <= 3'h1;
         cnt_q     <= 3'h0;
         req_n     <= 1'b1;
         frame_n_o <= 1'b1;
         frame_n_oe <= 1'b0;
         irdy_n_o  <= 1'b1;
         irdy_n_oe <= 1'b0;
         addr_o    <= 30'h0;
         addr_oe   <= 1'b0;
         wr_o      <= 1'b0;
         wr_oe     <= 1'b0;
         done_q    <= 1'b0;
         stopd_q   <= 1'b0;
      end else begin
         case (mst_q)
            M_IDLE: begin
               if (start_q) begin
                  done_q  <= 1'b0;
                  stopd_q <= 1'b0;
                  cnt_q   <= 3'h0;
                  req_n   <= 1'b0;
                  if (!(burst_enable_bit_q && mode_s))     // [RQ10]
                     nwords_q <= 3'h1;                     // [RQ11]
                  else if (!mdesc_q)
                     nwords_q <= 3'h1;                     // [RQ12]
                  else if (req_len > `DSB_DESC_MAX)
                     nwords_q <= `DSB_DESC_MAX;            // [RQ12]
                  else
                     nwords_q <= req_len;
               end
               if (!req_n && !gnt_n_s && frame_s && irdy_s && !slv_busy)
               begin
                  mst_q      <= M_ADDR;
                  req_n      <= 1'b1;
                  frame_n_o  <= 1'b0;                      // [RQ3]
                  frame_n_oe <= 1'b1;
                  addr_o     <= maddr_q;                   // [RQ5] [RQ6]
                  addr_oe    <= 1'b1;
                  wr_o       <= mdir_q;                    // [RQ4] [RQ14]
                  wr_oe      <= 1'b1;                      // [RQ7]
                  irdy_n_oe  <= 1'b1;
               end
            end
            M_ADDR: begin
               mst_q <= M_DATA;
               irdy_n_o <= !room;
               if (nwords_q == 3'h1 && room) frame_n_o <= 1'b1;
            end
            M_DATA: begin
               if (ack) begin
                  // Address is held, not advanced, for later words
                  if (!trdy_s) cnt_q <= cnt_q + 3'h1;      // [RQ8] [RQ9]
                  irdy_n_o <= 1'b1;
                  if (!stop_s || cnt_q + 3'h1 >= nwords_q) begin
                     frame_n_o <= 1'b1;                    // [RQ13]
                     stopd_q   <= !stop_s;
                     mst_q     <= M_TURN;
                  end else begin
                     mst_q <= M_GAP;
                  end
               end else begin
                  irdy_n_o <= !room;
                  if (room && cnt_q + 3'h1 >= nwords_q) frame_n_o <= 1'b1;
               end
            end
            M_GAP: begin
               // Ready is seen late; wait for its release before next word
               if (trdy_s) begin                           // [RQ16]
                  mst_q    <= M_DATA;
                  irdy_n_o <= !room;
                  if (room && cnt_q + 3'h1 >= nwords_q) frame_n_o <= 1'b1;
               end
            end
            M_TURN: begin
               mst_q      <= M_IDLE;
               done_q     <= 1'b1;
               frame_n_oe <= 1'b0;
               irdy_n_oe  <= 1'b0;
               addr_oe    <= 1'b0;
               wr_oe      <= 1'b0;
            end
            default: mst_q <= M_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave target: one data phase, burst attempts disconnected with stop
   dsb_slv_type slv_q;
   logic        cfg_q, hit;
   logic [1:0]  sidx_q;

   assign slv_busy = slv_q != S_IDLE;
   assign hit = mode_s && frame_p_q && !frame_s && mst_q == M_IDLE &&
                (idsel_s || addr_s[29:4] == SLV_BASE);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         slv_q       <= S_IDLE;
         frame_p_q   <= 1'b1;
         cfg_q       <= 1'b0;
         sidx_q      <= 2'h0;
         slv_reg_q   <= `DSB_RST_WORD;
         devsel_n_o  <= 1'b1;
         devsel_n_oe <= 1'b0;
         trdy_n_o    <= 1'b1;
         trdy_n_oe   <= 1'b0;
         stop_n_o    <= 1'b1;
         stop_n_oe   <= 1'b0;
         ad_o        <= 32'h0;
         ad_oe       <= 1'b0;
      end else begin
         frame_p_q <= frame_s;
         case (slv_q)
            S_IDLE: if (hit) begin
               slv_q       <= S_WAIT;
               cfg_q       <= idsel_s;                     // [RQ15]
               sidx_q      <= addr_s[1:0];
               devsel_n_o  <= 1'b0;
               devsel_n_oe <= 1'b1;
               trdy_n_oe   <= 1'b1;
               stop_n_oe   <= 1'b1;
            end
            S_WAIT: if (!irdy_s) begin
               slv_q    <= S_DATA;
               trdy_n_o <= 1'b0;
               stop_n_o <= frame_s;
               ad_oe    <= !wr_s;
               if (cfg_q) ad_o <= (sidx_q == 2'h0) ? ID_WORD : 32'h0;
               else if (sidx_q == 2'h0) ad_o <= slv_reg_q;
               else if (sidx_q == 2'h1)
                  ad_o <= {30'h0, mode_s, burst_enable_bit_q};
               else ad_o <= 32'h0;
               if (wr_s && !cfg_q && sidx_q == 2'h0) slv_reg_q <= ad_s;
            end
            S_DATA: begin
               slv_q       <= S_END;
               trdy_n_o    <= 1'b1;
               stop_n_o    <= 1'b1;
               devsel_n_o  <= 1'b1;
               ad_oe       <= 1'b0;
            end
            S_END: if (frame_s && irdy_s) begin
               slv_q       <= S_IDLE;
               devsel_n_oe <= 1'b0;
               trdy_n_oe   <= 1'b0;
               stop_n_oe   <= 1'b0;
            end
            default: slv_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_addr_phase;
      mst_q == M_IDLE ##1 mst_q == M_ADDR;
   endsequence
   sequence s_data_start;
      mst_q == M_DATA && frame_n_oe && irdy_n_oe;
   endsequence

   a_addr_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
      mst_q != M_IDLE && $past(mst_q) != M_IDLE |->
      $stable(addr_o)) // [RQ8]
      else $error("Master address moved inside a transaction");
   a_strobe_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!frame_n_o || !irdy_n_o) && $past(!frame_n_o || !irdy_n_o) |->
      $stable(wr_o) && wr_oe) // [RQ7]
      else $error("Write strobe moved during a transaction");
   a_addr_valid: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_addr_phase |-> !frame_n_o && addr_oe && addr_o == maddr_q) // [RQ6]
      else $error("Address not valid with frame assertion");
   a_phase_order: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_addr_phase |-> ##1 s_data_start) // [RQ3]
      else $error("Data phase does not follow address phase");
   a_single_word: assert property (@(posedge sys_clk) disable iff (!rstn)
      mst_q == M_ADDR && (!burst_enable_bit_q || !mdesc_q) |->
      nwords_q == 3'h1) // [RQ11]
      else $error("Burst length with bursts disabled");
   a_desc_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
      mst_q != M_IDLE |-> nwords_q <= `DSB_DESC_MAX &&
      nwords_q != 3'h0) // [RQ12]
      else $error("Master burst longer than three words");
   a_stop_ends: assert property (@(posedge sys_clk) disable iff (!rstn)
      ack && !stop_s |-> ##1 mst_q == M_TURN && frame_n_o ##1
      mst_q == M_IDLE && !frame_n_oe) // [RQ13]
      else $error("Target stop did not end the transaction");
   a_cmd_encode: assert property (@(posedge sys_clk) disable iff (!rstn)
      mst_q == M_ADDR |-> wr_o == mdir_q && mode_s) // [RQ14]
      else $error("Master strobe does not match direction");
   a_slave_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
      slv_q == S_IDLE && hit |-> ##1 cfg_q == $past(idsel_s)) // [RQ15]
      else $error("Slave space decode wrong");
   a_no_cnt_pass: assert property (@(posedge sys_clk) disable iff (!rstn)
      mst_q == M_DATA |-> cnt_q < nwords_q) // [RQ1]
      else $error("Master transferred past its length");
endmodule

// ==== dv/dsb_glue_model.sv ====
`timescale 1ns/100ps
module dsb_glue_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // Behaviour controls
   input  wire logic [3:0]  wait_cyc,
   input  wire logic [2:0]  stop_at,
   // Resolved bus wires
   input  wire logic        req_n,
   input  wire logic        frame_n,
   input  wire logic        irdy_n,
   input  wire logic [29:0] addr,
   input  wire logic        wr,
   output logic             gnt_n,
   output logic             trdy_n,
   output logic             stop_n,
   output logic             devsel_n,
   output logic      [31:0] ad,
   // Observations
   output logic      [7:0]  frames,
   output logic      [2:0]  words,
   output logic      [29:0] addr_seen,
   output logic             wr_seen,
   output logic      [7:0]  slips
);
   logic        frame_q;
   logic [3:0]  cnt_q;
   logic [2:0]  hold_q;
   logic [31:0] last_q;
   // Released data lines show the inverse, never a stale copy
   assign ad = trdy_n ? ~last_q : last_q;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {gnt_n, trdy_n, stop_n, devsel_n, frame_q} <= 5'h1F;
         {frames, words, slips, cnt_q, hold_q} <= '0;
         {addr_seen, wr_seen, last_q} <= '0;
      end else begin
         gnt_n   <= req_n;
         frame_q <= frame_n;
         trdy_n  <= 1'b1;
         stop_n  <= 1'b1;
         if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
         if (frame_q && !frame_n) begin
            frames    <= frames + 8'h1;
            words     <= 3'h0;
            addr_seen <= addr;
            wr_seen   <= wr;
            devsel_n  <= 1'b0;
         end else if (!devsel_n) begin
            // Every word served from one address: glue would increment
            if (!(frame_n && irdy_n) && (addr !== addr_seen || wr !== wr_seen))
               slips <= slips + 8'h1;
            if (frame_n && irdy_n && hold_q == 3'h0) devsel_n <= 1'b1;
            // Hold-off skips the irdy still low from the last word
            if (!irdy_n && hold_q == 3'h0) begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q >= wait_cyc) begin
                  cnt_q  <= 4'h0;
                  hold_q <= 3'h4;
                  if (|stop_at && words == stop_at) stop_n <= 1'b0;
                  else begin
                     trdy_n <= 1'b0;
                     words  <= words + 3'h1;
                     last_q <= {16'hDA7A, frames, 5'h0, words};
                  end
               end
            end
         end
      end
   end
endmodule

// ==== dv/tb_dsb_top.sv ====
`timescale 1ns/100ps
`include "dsb_cfg.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_dsb_top;
   logic        sys_clk, rstn, avs_read, avs_write, bus_mode_select;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, avs_ret, ad_o, p_ad;
   logic        avs_waitrequest, gnt_n, req_n, wr_o, wr_oe, ad_oe, addr_oe;
   logic        frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, trdy_n_o;
   logic        trdy_n_oe, stop_n_o, stop_n_oe, devsel_n_o, devsel_n_oe;
   logic        p_trdy, p_stop, p_devsel, wr_seen;
   logic [29:0] addr_o, addr_seen;
   logic [7:0]  frames, slips, fr;
   logic [3:0]  wait_cyc;
   logic [2:0]  stop_at, words;
   int          error_cnt, checks;
   // Handshakes pulled up; undriven address and strobe float high, undriven data lines show the glue's ad
   wire frame_w  = frame_n_o | ~frame_n_oe;
   wire irdy_w   = irdy_n_o | ~irdy_n_oe;
   wire trdy_w   = p_trdy & (trdy_n_o | ~trdy_n_oe);
   wire stop_w   = p_stop & (stop_n_o | ~stop_n_oe);
   wire devsel_w = p_devsel & (devsel_n_o | ~devsel_n_oe);
   wire wr_w     = wr_o | ~wr_oe;
   wire [29:0] addr_w = addr_oe ? addr_o : {30{1'b1}};
   wire [31:0] ad_w   = ad_oe ? ad_o : p_ad;
   ////////////////////////////////////////////////////////////////////////
   dsb_top u_dsb_top (
      .sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .bus_mode_select, .idsel(1'b0),
      .gnt_n, .req_n, .frame_n_i(frame_w), .frame_n_o, .frame_n_oe,
      .irdy_n_i(irdy_w), .irdy_n_o, .irdy_n_oe, .trdy_n_i(trdy_w), .trdy_n_o,
      .trdy_n_oe, .stop_n_i(stop_w), .stop_n_o, .stop_n_oe,
      .devsel_n_i(devsel_w), .devsel_n_o, .devsel_n_oe, .addr_i(addr_w),
      .addr_o, .addr_oe, .wr_i(wr_w), .wr_o, .wr_oe, .ad_i(ad_w), .ad_o,
      .ad_oe);
   dsb_glue_model u_dsb_glue_model (
      .sys_clk, .rstn, .wait_cyc, .stop_at, .req_n, .frame_n(frame_w),
      .irdy_n(irdy_w), .addr(addr_w), .wr(wr_w), .gnt_n, .trdy_n(p_trdy),
      .stop_n(p_stop), .devsel_n(p_devsel), .ad(p_ad), .frames, .words,
      .addr_seen, .wr_seen, .slips);
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic av(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      avs_ret = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n == 20) begin error_cnt++; conclude(); end
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      `CHK("readdata", e, avs_ret)
   endtask
   function automatic logic [31:0] dat(input logic [7:0] f, input int w);
      return {16'hDA7A, f, 5'h0, w[2:0]};
   endfunction
   task automatic fin(input logic [2:0] n);
      int k;
      k = 0;
      do begin
         av(1'b0, `DSB_OFF_MSTAT, 32'h0);
         k++;
      end while (avs_ret[1:0] !== 2'b10 && k < 60);
      if (k == 60) begin error_cnt++; conclude(); end
      fr++;
      `CHK("count", n, avs_ret[6:4])
      `CHK("served", n, words)
      `CHK("frames", fr, frames)
      `CHK("address", 30'h048D159C, addr_seen)
      `CHK("slips", 8'h0, slips)
   endtask
   task automatic xfer(input logic [3:0] cmd, input logic [2:0] n);
      av(1'b1, `DSB_OFF_MCMD, {28'h0, cmd});
      fin(n);
      `CHK("direction", cmd[0], wr_seen)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rdc(`DSB_OFF_SETUP, 32'h2);
      rdc(`DSB_OFF_MSTAT, 32'h0);
      rdc(`DSB_OFF_RDATA, 32'h0);
      rdc(6'h1C, 32'h0);
      av(1'b1, `DSB_OFF_SLVREG, 32'hC3A5_5A3C);
      rdc(`DSB_OFF_SLVREG, 32'h0);
      av(1'b1, `DSB_OFF_MADDR, 32'h1234_5670);
      $display("test regs done");
   endtask
   task automatic t_single();
      av(1'b1, `DSB_OFF_SETUP, 32'h0);
      xfer(4'hE, 3'h1);
      rdc(`DSB_OFF_RDATA, dat(fr, 0));
      rdc(`DSB_OFF_RDATA, 32'h0);
      xfer(4'hF, 3'h1);
      $display("test single done");
   endtask
   task automatic t_burst();
      av(1'b1, `DSB_OFF_SETUP, 32'h1);
      rdc(`DSB_OFF_SETUP, 32'h3);
      xfer(4'hE, 3'h3);
      for (int i = 0; i < 3; i++) rdc(`DSB_OFF_RDATA, dat(fr, i));
      wait_cyc <= 4'h5;
      xfer(4'hF, 3'h3);
      wait_cyc <= 4'h0;
      xfer(4'hD, 3'h1);
      xfer(4'h6, 3'h2);
      for (int i = 0; i < 2; i++) rdc(`DSB_OFF_RDATA, dat(fr, i));
      stop_at <= 3'h1;
      xfer(4'hB, 3'h1);
      `CHK("stopped", 1'b1, avs_ret[2])
      stop_at <= 3'h0;
      $display("test burst done");
   endtask
   task automatic t_fifo();
      logic [7:0] b;
      av(1'b1, `DSB_OFF_SETUP, 32'h0);
      b = fr;
      for (int i = 0; i < 8; i++) xfer(4'h0, 3'h1);
      av(1'b1, `DSB_OFF_MCMD, 32'h0);
      repeat (20) @(posedge sys_clk);
      rdc(`DSB_OFF_MSTAT, 32'h1);
      for (int i = 1; i < 9; i++) rdc(`DSB_OFF_RDATA, dat(b + i[7:0], 0));
      fin(3'h1);
      rdc(`DSB_OFF_RDATA, dat(fr, 0));
      rdc(`DSB_OFF_RDATA, 32'h0);
      $display("test fifo done");
   endtask
   task automatic t_mode();
      bus_mode_select <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rdc(`DSB_OFF_SETUP, 32'h0);
      av(1'b1, `DSB_OFF_MCMD, 32'hE);
      repeat (12) @(posedge sys_clk);
      `CHK("frames", fr, frames)
      av(1'b0, `DSB_OFF_MSTAT, 32'h0);
      `CHK("error", 1'b1, avs_ret[3])
      av(1'b1, `DSB_OFF_MSTAT, 32'h0);
      av(1'b0, `DSB_OFF_MSTAT, 32'h0);
      `CHK("error", 1'b0, avs_ret[3])
      bus_mode_select <= 1'b1;
      repeat (4) @(posedge sys_clk);
      $display("test mode done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (30000) @(posedge sys_clk);
      error_cnt++;
      conclude();
   end
   initial begin
      {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {wait_cyc, stop_at, fr, error_cnt, checks} = '0;
      bus_mode_select = 1'b1;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_regs();
      t_single();
      t_burst();
      t_fifo();
      t_mode();
      conclude();
   end
endmodule
